// File: core/pfs_defs.svh
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH

// ==========================================================================
// Register map
`define PFS_ADDR_W        8
`define PFS_FUNC_OFS      8'h34
`define PFS_ALT_OFS       8'h38
`define PFS_FUNC_RST      32'h0000_0000
`define PFS_ALT_RST       32'h0000_0000

// ==========================================================================
// Field positions
`define PFS_SCHMITT_MSB   31
`define PFS_SCHMITT_LSB   16
`define PFS_MAIN_MSB      15
`define PFS_MAIN_LSB      0
`define PFS_PIN15_BIT     15
`define PFS_PIN14_BIT     14
`define PFS_PIN13_BIT     13
`define PFS_ALT_CAP_BIT   24
`define PFS_ALT_SPI_BIT   3
`define PFS_ALT_EBI_BIT   11

`endif

// File: core/pfs_pkg.sv
`default_nettype none

// ==========================================================================
// Types
package pfs_pkg;

    typedef enum logic [1:0] {
        PFS_FN_GPIO  = 2'b00,
        PFS_FN_MAIN  = 2'b01,
        PFS_FN_ALT   = 2'b10
    } pfs_func_e;

    typedef struct packed {
        pfs_func_e pin15;
        pfs_func_e pin14;
        pfs_func_e pin13;
    } pfs_pin_fn_s;

endpackage : pfs_pkg

`default_nettype wire

// File: core/pfs_pin_sel.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// One pin's three-way function decode
module pfs_pin_sel (
    input  wire logic              main_sel_i,
    input  wire logic              alt_sel_i,
    output var  pfs_pkg::pfs_func_e func_o
);
    import pfs_pkg::*;

    always_comb begin
        // Alternate bit is a don't-care while the main bit is clear
        if (!main_sel_i) begin // [RULE6]
            func_o = PFS_FN_GPIO;
        end else if (alt_sel_i) begin
            func_o = PFS_FN_ALT;
        end else begin
            func_o = PFS_FN_MAIN;
        end
    end

endmodule : pfs_pin_sel

`default_nettype wire

// File: core/pfs_pin_mux.sv
// Behaviour
// [RULE1] A 32-bit read-write port B function register sits at offset 0x34 and resets to zero.
// [RULE2] Each of bits 31..16 enables the Schmitt input of the matching port B pin when one.
// [RULE3] Pin 15 is GPIO when its main bit is zero, else interrupt 1 or, with alt bit 24, timer 0 capture.
// [RULE4] Pin 14 is GPIO when its main bit is zero, else interrupt 0 or, with alt bit 3, SPI3 select 1.
// [RULE5] Pin 13 is GPIO when its main bit is zero, else comparator 1 or, with bus enable, bus bit 1.
// [RULE6] A clear main bit gives GPIO whatever the alternate bit holds.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pfs_defs.svh"

module pfs_pin_mux (
    input  wire logic                      clk_i,
    input  wire logic                      rstn_i,
    input  wire logic [`PFS_ADDR_W-1:0]    addr_i,
    input  wire logic [31:0]               wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    output logic      [31:0]               rdata_o,
    output logic      [15:0]               schmitt_en_o,
    output logic      [15:0]               main_sel_o,
    output logic                           pin15_capture_alt_select_o,
    output logic                           pin14_spi_alt_select_o,
    output logic                           external_bus_enable_o,
    output pfs_pkg::pfs_pin_fn_s           pin_fn_o
);
    import pfs_pkg::*;

    // ======================================================================
    // Address decode
    function automatic logic reg_hit(input logic [`PFS_ADDR_W-1:0] a,
                                     input logic [`PFS_ADDR_W-1:0] ofs);
        reg_hit = (a == ofs);
    endfunction : reg_hit

    // ======================================================================
    // Register file
    logic [31:0] func_r;
    logic [31:0] func_nxt;
    logic [31:0] alt_r;
    logic [31:0] alt_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [31:0] alt_mask;

    // Only the three alternate bits this block steers are kept; the rest read zero
    assign alt_mask = (32'h1 << `PFS_ALT_CAP_BIT) | (32'h1 << `PFS_ALT_SPI_BIT)
                    | (32'h1 << `PFS_ALT_EBI_BIT);

    // Synchronous reset sits in the next-state logic, so the flops stay plain
    always_comb begin
        func_nxt  = func_r;
        alt_nxt   = alt_r;
        rdata_nxt = 32'h0000_0000;
        if (!rstn_i) begin
            func_nxt = `PFS_FUNC_RST; // [RULE1]
            alt_nxt  = `PFS_ALT_RST;
        end else begin
            if (wr_i && reg_hit(addr_i, `PFS_FUNC_OFS)) begin
                func_nxt = wdata_i; // [RULE1]
            end
            if (wr_i && reg_hit(addr_i, `PFS_ALT_OFS)) begin
                alt_nxt = wdata_i & alt_mask;
            end
            if (rd_i && reg_hit(addr_i, `PFS_FUNC_OFS)) begin
                rdata_nxt = func_r; // [RULE1]
            end else if (rd_i && reg_hit(addr_i, `PFS_ALT_OFS)) begin
                rdata_nxt = alt_r;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        func_r  <= func_nxt;
        alt_r   <= alt_nxt;
        rdata_r <= rdata_nxt;
    end

    // Outputs tap the flops directly, with no logic after them
    assign rdata_o                    = rdata_r;
    assign schmitt_en_o               = func_r[`PFS_SCHMITT_MSB:`PFS_SCHMITT_LSB]; // [RULE2]
    assign main_sel_o                 = func_r[`PFS_MAIN_MSB:`PFS_MAIN_LSB];
    assign pin15_capture_alt_select_o = alt_r[`PFS_ALT_CAP_BIT];
    assign pin14_spi_alt_select_o     = alt_r[`PFS_ALT_SPI_BIT];
    assign external_bus_enable_o      = alt_r[`PFS_ALT_EBI_BIT];

    // ======================================================================
    // Pin function selection
    // Registered so the pad mux sees glitch-free codes, at one cycle of lag
    pfs_pin_fn_s fn_r;
    pfs_pin_fn_s fn_nxt;
    pfs_func_e   dec15;
    pfs_func_e   dec14;
    pfs_func_e   dec13;

    // Each pin decodes its own main bit against its own alternate bit
    pfs_pin_sel u_sel15 (
        .main_sel_i (func_r[`PFS_PIN15_BIT]),
        .alt_sel_i  (alt_r[`PFS_ALT_CAP_BIT]),
        .func_o     (dec15)
    ); // [RULE3]

    pfs_pin_sel u_sel14 (
        .main_sel_i (func_r[`PFS_PIN14_BIT]),
        .alt_sel_i  (alt_r[`PFS_ALT_SPI_BIT]),
        .func_o     (dec14)
    ); // [RULE4]

    pfs_pin_sel u_sel13 (
        .main_sel_i (func_r[`PFS_PIN13_BIT]),
        .alt_sel_i  (alt_r[`PFS_ALT_EBI_BIT]),
        .func_o     (dec13)
    ); // [RULE5]

    always_comb begin
        if (!rstn_i) begin
            fn_nxt = '{PFS_FN_GPIO, PFS_FN_GPIO, PFS_FN_GPIO};
        end else begin
            fn_nxt = '{dec15, dec14, dec13};
        end
    end

    always_ff @(posedge clk_i) begin
        fn_r <= fn_nxt;
    end

    assign pin_fn_o = fn_r;

    // ======================================================================
    // Assertions
    // Bus, register and pin function checks
    a_reset_clears: assert property (@(posedge clk_i) // [RULE1]
        !rstn_i |=> (func_r == 32'h0000_0000) && (rdata_o == 32'h0000_0000))
        else $error("function register not cleared by reset");

    a_read_back: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE1]
        wr_i && reg_hit(addr_i, `PFS_FUNC_OFS) ##1 rd_i && reg_hit(addr_i, `PFS_FUNC_OFS)
        |=> rdata_o == $past(wdata_i, 2))
        else $error("function register read-back differs from write");

    a_schmitt_map: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE2]
        wr_i && reg_hit(addr_i, `PFS_FUNC_OFS) |=> schmitt_en_o == $past(wdata_i[31:16]))
        else $error("Schmitt enables do not follow upper bits");

    a_pin15_fn: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE3]
        $past(rstn_i) |-> pin_fn_o.pin15 == (!$past(func_r[`PFS_PIN15_BIT]) ? PFS_FN_GPIO :
            ($past(alt_r[`PFS_ALT_CAP_BIT]) ? PFS_FN_ALT : PFS_FN_MAIN)))
        else $error("pin 15 function wrong");

    a_pin14_fn: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE4]
        $past(rstn_i) |-> pin_fn_o.pin14 == (!$past(func_r[`PFS_PIN14_BIT]) ? PFS_FN_GPIO :
            ($past(alt_r[`PFS_ALT_SPI_BIT]) ? PFS_FN_ALT : PFS_FN_MAIN)))
        else $error("pin 14 function wrong");

    a_pin13_fn: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE5]
        $past(rstn_i) |-> pin_fn_o.pin13 == (!$past(func_r[`PFS_PIN13_BIT]) ? PFS_FN_GPIO :
            ($past(alt_r[`PFS_ALT_EBI_BIT]) ? PFS_FN_ALT : PFS_FN_MAIN)))
        else $error("pin 13 function wrong");

    a_alt_ignored: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE6]
        !func_r[`PFS_PIN13_BIT] && alt_r[`PFS_ALT_EBI_BIT] ##1 rstn_i
        |-> pin_fn_o.pin13 == PFS_FN_GPIO)
        else $error("alternate bit acted with main bit clear");

    a_rdata_idle: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE1]
        !rd_i |=> rdata_o == 32'h0000_0000)
        else $error("read data not zero outside a read");

    a_rdata_unmapped: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE1]
        rd_i && !reg_hit(addr_i, `PFS_FUNC_OFS) && !reg_hit(addr_i, `PFS_ALT_OFS)
        |=> rdata_o == 32'h0000_0000)
        else $error("unmapped read returned data");

    a_func_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE1]
        !(wr_i && reg_hit(addr_i, `PFS_FUNC_OFS)) |=> $stable(func_r))
        else $error("function register changed without a write");

    a_alt_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE3]
        !(wr_i && reg_hit(addr_i, `PFS_ALT_OFS)) |=> $stable(alt_r))
        else $error("alternate register changed without a write");

    a_main_map: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE3]
        wr_i && reg_hit(addr_i, `PFS_FUNC_OFS) |=> main_sel_o == $past(wdata_i[15:0]))
        else $error("main select bits do not follow lower bits");

    // Mask spelt out on its own, so a wrong field position in the defines shows up here
    a_alt_write: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE3]
        wr_i && reg_hit(addr_i, `PFS_ALT_OFS) |=> alt_r == ($past(wdata_i) & 32'h0100_0808))
        else $error("alternate register kept unused bits");

    a_alt_read_back: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE4]
        wr_i && reg_hit(addr_i, `PFS_ALT_OFS) ##1 rd_i && reg_hit(addr_i, `PFS_ALT_OFS)
        |=> rdata_o == ($past(wdata_i, 2) & 32'h0100_0808))
        else $error("alternate register read-back differs from write");

    // Pin decode checks, one cycle behind the register bits
    a_reset_gpio: assert property (@(posedge clk_i) // [RULE1]
        !rstn_i |=> pin_fn_o == 6'h00)
        else $error("pins not GPIO after reset");

    a_pin15_gpio: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE6]
        !func_r[`PFS_PIN15_BIT] ##1 rstn_i |-> pin_fn_o.pin15 == PFS_FN_GPIO)
        else $error("pin 15 not GPIO with main bit clear");

    a_pin14_gpio: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE6]
        !func_r[`PFS_PIN14_BIT] ##1 rstn_i |-> pin_fn_o.pin14 == PFS_FN_GPIO)
        else $error("pin 14 not GPIO with main bit clear");

    // ======================================================================
    // Coverage
    c_capture_sel: cover property (@(posedge clk_i) disable iff (!rstn_i)
        pin_fn_o.pin15 == PFS_FN_ALT);
    c_bus_sel: cover property (@(posedge clk_i) disable iff (!rstn_i)
        pin_fn_o.pin13 == PFS_FN_ALT);
    c_irq0_sel: cover property (@(posedge clk_i) disable iff (!rstn_i)
        pin_fn_o.pin14 == PFS_FN_MAIN);
    c_alt_read: cover property (@(posedge clk_i) disable iff (!rstn_i)
        rd_i && reg_hit(addr_i, `PFS_ALT_OFS) ##1 rdata_o != 32'h0000_0000);
    c_back_to_back: cover property (@(posedge clk_i) disable iff (!rstn_i)
        wr_i ##1 rd_i);

endmodule : pfs_pin_mux

`default_nettype wire

// File: bench/pfs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfs_defs.svh"

// ==========================================================================
// Bench for the port B function select
module testbench;
    import pfs_pkg::*;

    localparam int          LIMIT = 2000;
    logic                   clk_i = 1'b0;
    logic                   rstn_i = 1'b0;
    logic [7:0]             addr_i = 8'h00;
    logic [31:0]            wdata_i = 32'h0000_0000;
    logic                   wr_i = 1'b0;
    logic                   rd_i = 1'b0;
    logic [31:0]            rdata_o;
    logic [15:0]            schmitt_en_o;
    logic [15:0]            main_sel_o;
    logic                   pin15_capture_alt_select_o;
    logic                   pin14_spi_alt_select_o;
    logic                   external_bus_enable_o;
    pfs_pin_fn_s            pin_fn_o;
    int                     fails = 0;
    int                     num_checks = 0;
    int                     cyc = 0;
    logic [31:0]            rd_v;
    logic [5:0]             exp_fn;

    always #50 clk_i = ~clk_i;

    pfs_pin_mux dut (
        .clk_i                      (clk_i),
        .rstn_i                     (rstn_i),
        .addr_i                     (addr_i),
        .wdata_i                    (wdata_i),
        .wr_i                       (wr_i),
        .rd_i                       (rd_i),
        .rdata_o                    (rdata_o),
        .schmitt_en_o               (schmitt_en_o),
        .main_sel_o                 (main_sel_o),
        .pin15_capture_alt_select_o (pin15_capture_alt_select_o),
        .pin14_spi_alt_select_o     (pin14_spi_alt_select_o),
        .external_bus_enable_o      (external_bus_enable_o),
        .pin_fn_o                   (pin_fn_o)
    );

    // ======================================================================
    // Bus tasks and checks
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    // Read data stands only one cycle, so it is taken just after the edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd

    // Write strobe followed at once by a read strobe, with no idle cycle
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        q = rdata_o;
    endtask : wr_rd

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [1:0] fn(input logic m, input logic a);
        return m ? (a ? PFS_FN_ALT : PFS_FN_MAIN) : PFS_FN_GPIO;
    endfunction : fn

    task automatic test_done();
        if (fails == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // Hang guard: the whole sequence needs well under two hundred cycles
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fails++;
            test_done();
        end
    end

    // ======================================================================
    // Sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(`PFS_FUNC_OFS, rd_v);
        chk(rd_v, `PFS_FUNC_RST);
        chk({26'h0, pin_fn_o}, 32'h0000_0000);
        wr(`PFS_FUNC_OFS, 32'hA5C3_9E71);
        #1;
        chk({schmitt_en_o, main_sel_o}, 32'hA5C3_9E71);
        rd(`PFS_FUNC_OFS, rd_v);
        chk(rd_v, 32'hA5C3_9E71);
        wr(`PFS_FUNC_OFS, 32'h5A3C_0000);
        #1;
        chk({16'h0, schmitt_en_o}, 32'h0000_5A3C);
        // Unmapped write must not alias onto the function register
        wr(8'h3C, 32'hFFFF_FFFF);
        rd(8'h3C, rd_v);
        chk(rd_v, 32'h0000_0000);
        rd(`PFS_FUNC_OFS, rd_v);
        chk(rd_v, 32'h5A3C_0000);
        wr_rd(`PFS_FUNC_OFS, 32'h0F0F_1234, rd_v);
        chk(rd_v, 32'h0F0F_1234);
        // Read data stands for one cycle only
        @(posedge clk_i);
        #1;
        chk(rdata_o, 32'h0000_0000);
        for (int k = 0; k < 16; k++) begin
            wr(`PFS_FUNC_OFS, {16'h0, k[3], k[3], k[3], 13'h0});
            wr(`PFS_ALT_OFS, {7'h0, k[2], 12'h0, k[0], 7'h0, k[1], 3'h0});
            exp_fn = {fn(k[3], k[2]), fn(k[3], k[1]), fn(k[3], k[0])};
            repeat (2) @(posedge clk_i);
            #1;
            chk({29'h0, pin15_capture_alt_select_o, pin14_spi_alt_select_o,
                 external_bus_enable_o}, {29'h0, k[2], k[1], k[0]});
            chk({26'h0, pin_fn_o}, {26'h0, exp_fn});
        end
        // Alternate bits that no pin here uses are dropped on write
        wr_rd(`PFS_ALT_OFS, 32'hFFFF_FFFF, rd_v);
        chk(rd_v, 32'h0100_0808);
        test_done();
    end
endmodule : testbench

`default_nettype wire
